/* hw/two_channel_timer_pwm_irq.sv */
// Contract
// - pwm mode 2 uses one compare register as cycle, the A registers as duty.
// - cycle match clearing the counter returns each pin to its initial level.
// - duty equal to cycle value leaves the pin unchanged on match.
// - pwm mode 2 drives only the A pin of channel 1 and 2.
// - the register holding the period gives no pwm output.
// - events set sticky flags; irq while enabled; drops when flag clears.
// - fixed priority ch1 A, ch1 B, ch1 wrap, ch2 A, ch2 B, ch2 wrap.
// - four match sources, set by capture or compare on their register.
// - two wrap sources, one per channel, with their own enable.
// - match fires in the last equal cycle, as the counter updates.
// - no second match until the next counter clock tick.
// - flag cleared only by reading 1 then writing 0.
// - runs after reset; stop input halts it and blocks access.
// - clear on match gives a period of register value plus one.
// - counter clear beats a counter write in the same cycle.
// - counter write beats an increment in the same cycle.
// - compare register write suppresses the coinciding match.
// - each register A match can drive 0, drive 1 or toggle the pin.
// - wrap from all ones to zero sets the flag, counting continues.
module two_channel_timer_pwm_irq (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// module standby
	input wire logic module_stop,
	// per channel configuration
	input wire logic [1:0] count_start,
	input wire timer_pkg::clk_sel_e [1:0] clk_sel,
	input wire logic [1:0] ext_count_clk,
	input wire timer_pkg::clear_sel_e [1:0] clear_sel,
	input wire logic [1:0] pwm2_mode,
	input wire logic [1:0] capture_a_mode,
	input wire logic [1:0] capture_b_mode,
	// io_level_control fields
	input wire timer_pkg::pin_action_e [1:0] io_level_control,
	input wire logic [1:0] io_initial_level,
	input wire logic [1:0] io_initial_load,
	// capture requests
	input wire logic [1:0] capture_a_req,
	input wire logic [1:0] capture_b_req,
	// cpu writes
	input wire logic [1:0] count_wr,
	input wire logic [1:0] reg_a_wr,
	input wire logic [1:0] reg_b_wr,
	input wire logic [15:0] cpu_wdata,
	// irq_enable_reg fields
	input wire logic [1:0] match_a_irq_enable,
	input wire logic [1:0] match_b_irq_enable,
	input wire logic [1:0] overflow_irq_enable,
	// timer_status_reg access
	input wire logic status_rd,
	input wire logic status_wr,
	input wire logic [5:0] status_wdata,
	// readback
	output logic [15:0] ch1_count_value,
	output logic [15:0] ch2_count_value,
	output logic [15:0] ch1_reg_a,
	output logic [15:0] ch1_reg_b,
	output logic [15:0] ch2_reg_a,
	output logic [15:0] ch2_reg_b,
	output logic [5:0] timer_status_reg,
	// waveform pins
	output logic ch1_wave_pin_a,
	output logic ch1_wave_pin_a_oe,
	output logic ch2_wave_pin_a,
	output logic ch2_wave_pin_a_oe,
	// interrupt requests
	output logic ch1_a_match_irq,
	output logic ch1_b_match_irq,
	output logic ch1_wrap_irq,
	output logic ch2_a_match_irq,
	output logic ch2_b_match_irq,
	output logic ch2_wrap_irq,
	output logic [2:0] irq_top
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [1:0][15:0] count;
		logic [1:0][15:0] reg_a;
		logic [1:0][15:0] reg_b;
		logic [1:0] pin;
	} timer_state_s;

	timer_state_s state;
	timer_state_s next_state;

	logic access_en;
	logic [1:0] run;
	logic [1:0] tick;
	logic [1:0] eq_a;
	logic [1:0] eq_b;
	logic [1:0] match_a;
	logic [1:0] match_b;
	logic [1:0] cap_a;
	logic [1:0] cap_b;
	logic [1:0] own_clear;
	logic [1:0] clear;
	logic [1:0] wrap;
	logic [1:0] has_cycle;
	logic [1:0][15:0] cycle_val;
	logic [1:0][15:0] own_cycle_val;
	logic [1:0] own_has_cycle;
	logic [1:0] wr_cnt;
	logic [1:0] wr_a;
	logic [1:0] wr_b;
	logic [5:0] flag_set;
	logic [5:0] irq_enable;
	logic [5:0] irq_req;

	// ==========================================================
	// level action helper
	function automatic logic apply_action(
		input timer_pkg::pin_action_e act,
		input logic cur
	);
		logic res;
		res = cur;
		unique case (act)
			timer_pkg::ACT_NONE: res = cur;
			timer_pkg::ACT_LOW: res = 1'b0;
			timer_pkg::ACT_HIGH: res = 1'b1;
			timer_pkg::ACT_TOGGLE: res = ~cur;
		endcase
		return res;
	endfunction

	// ==========================================================
	// counter clock per channel
	assign access_en = ~module_stop;

	for (genvar c = 0; c < timer_pkg::NUM_CH; c++) begin : g_tick
		assign run[c] = count_start[c] & ~module_stop;
		count_tick u_tick (
			.clk_sys(clk_sys),
			.reset_n(reset_n),
			.run(run[c]),
			.clk_sel(clk_sel[c]),
			.ext_clk(ext_count_clk[c]),
			.tick(tick[c])
		);
	end

	// ==========================================================
	// match, clear and wrap events
	always_comb begin
		for (int c = 0; c < timer_pkg::NUM_CH; c++) begin
			wr_cnt[c] = access_en & count_wr[c];
			wr_a[c] = access_en & reg_a_wr[c];
			wr_b[c] = access_en & reg_b_wr[c];
			eq_a[c] = state.count[c] == state.reg_a[c];
			eq_b[c] = state.count[c] == state.reg_b[c];
			// match only on the tick that leaves the equal value
			match_a[c] = tick[c] & eq_a[c] & ~capture_a_mode[c]
				& ~wr_a[c];
			match_b[c] = tick[c] & eq_b[c] & ~capture_b_mode[c]
				& ~wr_b[c];
			cap_a[c] = capture_a_req[c] & capture_a_mode[c] & run[c];
			cap_b[c] = capture_b_req[c] & capture_b_mode[c] & run[c];
			own_clear[c] = 1'b0;
			own_has_cycle[c] = 1'b0;
			own_cycle_val[c] = timer_pkg::CNT_ZERO;
			unique case (clear_sel[c])
				timer_pkg::CLR_OFF: begin
					own_clear[c] = 1'b0;
				end
				timer_pkg::CLR_REG_A: begin
					own_clear[c] = match_a[c] | cap_a[c];
					own_has_cycle[c] = 1'b1;
					own_cycle_val[c] = state.reg_a[c];
				end
				timer_pkg::CLR_REG_B: begin
					own_clear[c] = match_b[c] | cap_b[c];
					own_has_cycle[c] = 1'b1;
					own_cycle_val[c] = state.reg_b[c];
				end
				timer_pkg::CLR_SYNC: begin
					own_clear[c] = 1'b0;
				end
			endcase
		end
		for (int c = 0; c < timer_pkg::NUM_CH; c++) begin
			// sync clear follows the other channel's clear source
			if (clear_sel[c] == timer_pkg::CLR_SYNC) begin
				clear[c] = own_clear[1 - c];
				has_cycle[c] = own_has_cycle[1 - c];
				cycle_val[c] = own_cycle_val[1 - c];
			end else begin
				clear[c] = own_clear[c];
				has_cycle[c] = own_has_cycle[c];
				cycle_val[c] = own_cycle_val[c];
			end
			// clear and cpu write both mask the wrap
			wrap[c] = tick[c] & (state.count[c] == timer_pkg::CNT_MAX)
				& ~clear[c] & ~wr_cnt[c];
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		next_state = state;
		for (int c = 0; c < timer_pkg::NUM_CH; c++) begin
			// counter: clear, then write, then increment
			if (clear[c]) begin
				next_state.count[c] = timer_pkg::CNT_ZERO;
			end else if (wr_cnt[c]) begin
				next_state.count[c] = cpu_wdata;
			end else if (tick[c]) begin
				next_state.count[c] = state.count[c] + 16'h0001;
			end
			// compare registers: capture takes the slot over a write
			if (cap_a[c]) begin
				next_state.reg_a[c] = state.count[c];
			end else if (wr_a[c]) begin
				next_state.reg_a[c] = cpu_wdata;
			end
			if (cap_b[c]) begin
				next_state.reg_b[c] = state.count[c];
			end else if (wr_b[c]) begin
				next_state.reg_b[c] = cpu_wdata;
			end
			// waveform pin A
			if (access_en && io_initial_load[c]) begin
				next_state.pin[c] = io_initial_level[c];
			end else if (capture_a_mode[c]) begin
				next_state.pin[c] = state.pin[c];
			end else if (pwm2_mode[c]) begin
				if (clear[c] && has_cycle[c]) begin
					next_state.pin[c] = io_initial_level[c];
				end else if (has_cycle[c] && clear_sel[c]
						== timer_pkg::CLR_REG_A) begin
					next_state.pin[c] = state.pin[c];
				end else if (match_a[c] && !(has_cycle[c]
						&& state.reg_a[c] == cycle_val[c])) begin
					next_state.pin[c] = apply_action(
						io_level_control[c], state.pin[c]);
				end
			end else if (match_a[c]) begin
				next_state.pin[c] = apply_action(
					io_level_control[c], state.pin[c]);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			for (int c = 0; c < timer_pkg::NUM_CH; c++) begin
				state.count[c] <= timer_pkg::COUNT_RESET;
				state.reg_a[c] <= timer_pkg::COMPARE_RESET;
				state.reg_b[c] <= timer_pkg::COMPARE_RESET;
				state.pin[c] <= timer_pkg::PIN_RESET;
			end
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// status flags and interrupt requests
	always_comb begin
		for (int c = 0; c < timer_pkg::NUM_CH; c++) begin
			flag_set[c * timer_pkg::FLAGS_PER_CH] =
				match_a[c] | cap_a[c];
			flag_set[c * timer_pkg::FLAGS_PER_CH + 1] =
				match_b[c] | cap_b[c];
			flag_set[c * timer_pkg::FLAGS_PER_CH + 2] = wrap[c];
			irq_enable[c * timer_pkg::FLAGS_PER_CH] =
				match_a_irq_enable[c];
			irq_enable[c * timer_pkg::FLAGS_PER_CH + 1] =
				match_b_irq_enable[c];
			irq_enable[c * timer_pkg::FLAGS_PER_CH + 2] =
				overflow_irq_enable[c];
		end
	end

	status_flags u_flags (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.flag_set(flag_set),
		.irq_enable(irq_enable),
		.access_en(access_en),
		.status_rd(status_rd),
		.status_wr(status_wr),
		.status_wdata(status_wdata),
		.flags(timer_status_reg),
		.irq_req(irq_req),
		.irq_top(irq_top)
	);

	// ==========================================================
	// outputs
	assign ch1_count_value = state.count[0];
	assign ch2_count_value = state.count[1];
	assign ch1_reg_a = state.reg_a[0];
	assign ch1_reg_b = state.reg_b[0];
	assign ch2_reg_a = state.reg_a[1];
	assign ch2_reg_b = state.reg_b[1];
	assign ch1_wave_pin_a = state.pin[0];
	assign ch2_wave_pin_a = state.pin[1];
	// pin is driven unless register A captures
	assign ch1_wave_pin_a_oe = ~capture_a_mode[0];
	assign ch2_wave_pin_a_oe = ~capture_a_mode[1];
	assign ch1_a_match_irq = irq_req[timer_pkg::FLAG_CH1_A];
	assign ch1_b_match_irq = irq_req[timer_pkg::FLAG_CH1_B];
	assign ch1_wrap_irq = irq_req[timer_pkg::FLAG_CH1_WRAP];
	assign ch2_a_match_irq = irq_req[timer_pkg::FLAG_CH2_A];
	assign ch2_b_match_irq = irq_req[timer_pkg::FLAG_CH2_B];
	assign ch2_wrap_irq = irq_req[timer_pkg::FLAG_CH2_WRAP];
endmodule

/* hw/timer_pkg.sv */
package timer_pkg;
	// ==========================================================
	// widths and fixed values
	localparam int CNT_W = 16;
	localparam int NUM_CH = 2;
	localparam int NUM_FLAGS = 6;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
	localparam logic PIN_RESET = 1'b0;

	// ==========================================================
	// flag positions, index 0 is the highest priority
	localparam int FLAG_CH1_A = 0;
	localparam int FLAG_CH1_B = 1;
	localparam int FLAG_CH1_WRAP = 2;
	localparam int FLAG_CH2_A = 3;
	localparam int FLAG_CH2_B = 4;
	localparam int FLAG_CH2_WRAP = 5;
	localparam int FLAGS_PER_CH = 3;
	localparam logic [2:0] IRQ_NONE = 3'h7;

	// ==========================================================
	// level action on compare match
	typedef enum logic [1:0] {
		ACT_NONE = 2'h0,
		ACT_LOW = 2'h1,
		ACT_HIGH = 2'h2,
		ACT_TOGGLE = 2'h3
	} pin_action_e;

	// counter clear source
	typedef enum logic [1:0] {
		CLR_OFF = 2'h0,
		CLR_REG_A = 2'h1,
		CLR_REG_B = 2'h2,
		CLR_SYNC = 2'h3
	} clear_sel_e;

	// counter clock source
	typedef enum logic [1:0] {
		CLK_INTERNAL = 2'h0,
		CLK_EXT_RISE = 2'h1,
		CLK_EXT_FALL = 2'h2,
		CLK_EXT_BOTH = 2'h3
	} clk_sel_e;
endpackage

/* hw/count_tick.sv */
module count_tick (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// control
	input wire logic run,
	input wire timer_pkg::clk_sel_e clk_sel,
	input wire logic ext_clk,
	// count enable
	output logic tick
);
	typedef struct packed {
		logic prev;
	} tick_state_s;

	tick_state_s state;
	tick_state_s next_state;
	logic rise;
	logic fall;

	always_comb begin
		next_state = state;
		next_state.prev = ext_clk;
		rise = ext_clk & ~state.prev;
		fall = ~ext_clk & state.prev;
		tick = 1'b0;
		unique case (clk_sel)
			timer_pkg::CLK_INTERNAL: tick = run;
			timer_pkg::CLK_EXT_RISE: tick = run & rise;
			timer_pkg::CLK_EXT_FALL: tick = run & fall;
			timer_pkg::CLK_EXT_BOTH: tick = run & (rise | fall);
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
endmodule

/* hw/status_flags.sv */
module status_flags (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// events and enables
	input wire logic [5:0] flag_set,
	input wire logic [5:0] irq_enable,
	// software access
	input wire logic access_en,
	input wire logic status_rd,
	input wire logic status_wr,
	input wire logic [5:0] status_wdata,
	// results
	output logic [5:0] flags,
	output logic [5:0] irq_req,
	output logic [2:0] irq_top
);
	typedef struct packed {
		logic [5:0] flag;
		logic [5:0] armed;
	} flag_state_s;

	flag_state_s state;
	flag_state_s next_state;

	always_comb begin
		next_state = state;
		irq_top = timer_pkg::IRQ_NONE;
		// clear only after the flag was seen as 1
		if (access_en && status_wr) begin
			next_state.flag = state.flag & ~(state.armed & ~status_wdata);
			next_state.armed = '0;
		end
		if (access_en && status_rd) begin
			next_state.armed = state.armed | state.flag;
		end
		next_state.flag = next_state.flag | flag_set;
		irq_req = state.flag & irq_enable;
		for (int i = timer_pkg::NUM_FLAGS - 1; i >= 0; i--) begin
			if (irq_req[i]) begin
				irq_top = 3'(i);
			end
		end
	end

	assign flags = state.flag;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
endmodule

/* test/timer_checker_properties.sv */
module timer_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// controls
	input wire logic module_stop,
	input wire logic [1:0] count_start,
	input wire timer_pkg::clk_sel_e [1:0] clk_sel,
	input wire timer_pkg::clear_sel_e [1:0] clear_sel,
	input wire logic [1:0] pwm2_mode,
	input wire logic [1:0] io_initial_level,
	input wire logic [1:0] count_wr,
	input wire logic [1:0] reg_a_wr,
	input wire logic [15:0] cpu_wdata,
	input wire logic status_rd,
	input wire logic status_wr,
	// observed
	input wire logic [15:0] ch1_count_value,
	input wire logic [15:0] ch2_count_value,
	input wire logic [15:0] ch1_reg_a,
	input wire logic [15:0] ch1_reg_b,
	input wire logic [5:0] timer_status_reg,
	input wire logic ch1_wave_pin_a,
	input wire logic ch1_a_match_irq,
	input wire logic [2:0] irq_top
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic [5:0] armed;
	logic run1;
	logic run2;
	logic eq1;
	assign run1 = count_start[0] && !module_stop
		&& clk_sel[0] == timer_pkg::CLK_INTERNAL;
	assign run2 = count_start[1] && !module_stop
		&& clk_sel[1] == timer_pkg::CLK_INTERNAL;
	assign eq1 = run1 && ch1_count_value == ch1_reg_a && !reg_a_wr[0];
	// flags seen as 1 by a read, until the next write
	always_ff @(posedge clk_sys) begin
		if (!reset_n || (status_wr && !module_stop))
			armed <= 6'h00;
		else if (status_rd && !module_stop)
			armed <= armed | timer_status_reg;
	end
	// ==========================================================
	// properties
	a_cycle_clear: assert property (eq1
		&& clear_sel[0] == timer_pkg::CLR_REG_A |=> ch1_count_value == 16'h0000)
		else $error("ch1 count not cleared on cycle match");
	a_match_flag: assert property (eq1 |=> timer_status_reg[0])
		else $error("ch1 match flag not set");
	a_write_store: assert property (count_wr[1] && !module_stop
		&& clear_sel[1] == timer_pkg::CLR_OFF
		|=> ch2_count_value == $past(cpu_wdata))
		else $error("ch2 count write lost");
	a_wrap_flag: assert property (run2 && ch2_count_value == 16'hFFFF
		&& !count_wr[1] && clear_sel[1] == timer_pkg::CLR_OFF
		|=> ch2_count_value == 16'h0000 && timer_status_reg[5])
		else $error("ch2 wrap not flagged");
	a_flag_fall: assert property ((~timer_status_reg
		& $past(timer_status_reg)
		& ~({6{$past(status_wr)}} & $past(armed))) == 6'h00)
		else $error("flag cleared without read and write");
	a_irq_order: assert property (ch1_a_match_irq |-> irq_top == 3'h0)
		else $error("top request not ch1 match a");
	a_match_suppress: assert property (run1 && reg_a_wr[0]
		&& ch1_count_value == ch1_reg_a && !count_wr[0]
		&& clear_sel[0] == timer_pkg::CLR_REG_A
		|=> ch1_count_value == $past(ch1_count_value) + 16'h0001)
		else $error("match not suppressed by write");
	a_stop_hold: assert property (module_stop |=> $stable(ch1_count_value)
		&& $stable(ch2_count_value))
		else $error("counter moved in standby");
	a_pwm_restart: assert property (run1 && pwm2_mode[0]
		&& clear_sel[0] == timer_pkg::CLR_REG_B && ch1_count_value == ch1_reg_b
		|=> ##[0:1] ch1_wave_pin_a == io_initial_level[0])
		else $error("pin not at initial level after cycle");
	c_match: cover property (eq1);
	c_wrap: cover property (run2 && ch2_count_value == 16'hFFFF);
	c_flag_clear: cover property (status_wr && armed != 6'h00);
endmodule

bind two_channel_timer_pwm_irq timer_checker i_chk (
	.clk_sys(clk_sys), .reset_n(reset_n), .module_stop(module_stop),
	.count_start(count_start), .clk_sel(clk_sel), .clear_sel(clear_sel),
	.pwm2_mode(pwm2_mode), .io_initial_level(io_initial_level),
	.count_wr(count_wr), .reg_a_wr(reg_a_wr), .cpu_wdata(cpu_wdata),
	.status_rd(status_rd), .status_wr(status_wr),
	.ch1_count_value(ch1_count_value), .ch2_count_value(ch2_count_value),
	.ch1_reg_a(ch1_reg_a), .ch1_reg_b(ch1_reg_b),
	.timer_status_reg(timer_status_reg), .ch1_wave_pin_a(ch1_wave_pin_a),
	.ch1_a_match_irq(ch1_a_match_irq), .irq_top(irq_top));

/* test/ext_clock_source.sv */
module ext_clock_source (
	// clock
	input wire logic clk_sys,
	// control
	input wire logic en,
	// external count clock
	output logic ext_clk
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] hold = 2'h0;
	initial ext_clk = 1'b0;
	// three cycles per level, idle low between bursts
	always @(posedge clk_sys) begin
		if (!en) begin
			ext_clk <= 1'b0;
			hold <= 2'h0;
		end else if (hold == 2'h2) begin
			ext_clk <= !ext_clk;
			hold <= 2'h0;
		end else
			hold <= hold + 2'h1;
	end
endmodule

/* test/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys;
	logic reset_n;
	logic module_stop;
	logic [1:0] count_start;
	timer_pkg::clk_sel_e [1:0] clk_sel;
	timer_pkg::clear_sel_e [1:0] clear_sel;
	timer_pkg::pin_action_e [1:0] io_level_control;
	logic [1:0] pwm2_mode;
	logic [1:0] io_initial_level;
	logic [1:0] count_wr;
	logic [1:0] reg_a_wr;
	logic [1:0] reg_b_wr;
	logic [15:0] cpu_wdata;
	logic [1:0] match_a_irq_enable;
	logic [1:0] match_b_irq_enable;
	logic [1:0] overflow_irq_enable;
	logic status_rd;
	logic status_wr;
	logic [5:0] status_wdata;
	logic [1:0] capture_b_mode;
	logic [1:0] capture_b_req;
	logic [1:0] io_initial_load;
	logic [15:0] ch2_reg_b;
	logic ch2_wave_pin_a;
	logic ch2_wave_pin_a_oe;
	logic src_en;
	logic ext_clk;
	logic [15:0] ch1_count_value;
	logic [15:0] ch2_count_value;
	logic [5:0] timer_status_reg;
	logic ch1_wave_pin_a;
	logic [5:0] irq;
	logic [2:0] irq_top;
	logic [15:0] r;
	logic [31:0] seed = 32'h0000A779;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	int sq[$];
	logic [15:0] eq[$];
	string nm[9] = '{"ch1_count", "ch2_count", "status", "irq", "irq_top",
		"ch1_pin", "ch2_reg_b", "ch2_b_flag", "ch2_oe_pin"};

	two_channel_timer_pwm_irq i_dut (
		.clk_sys(clk_sys), .reset_n(reset_n), .module_stop(module_stop),
		.count_start(count_start), .clk_sel(clk_sel),
		.ext_count_clk({ext_clk, ext_clk}), .clear_sel(clear_sel),
		.pwm2_mode(pwm2_mode), .capture_a_mode(2'b00),
		.capture_b_mode(capture_b_mode),
		.io_level_control(io_level_control), .io_initial_level(io_initial_level),
		.io_initial_load(io_initial_load), .capture_a_req(2'b00),
		.capture_b_req(capture_b_req),
		.count_wr(count_wr), .reg_a_wr(reg_a_wr), .reg_b_wr(reg_b_wr),
		.cpu_wdata(cpu_wdata), .match_a_irq_enable(match_a_irq_enable),
		.match_b_irq_enable(match_b_irq_enable),
		.overflow_irq_enable(overflow_irq_enable), .status_rd(status_rd),
		.status_wr(status_wr), .status_wdata(status_wdata),
		.ch1_count_value(ch1_count_value), .ch2_count_value(ch2_count_value),
		.ch1_reg_a(), .ch1_reg_b(), .ch2_reg_a(), .ch2_reg_b(ch2_reg_b),
		.timer_status_reg(timer_status_reg), .ch1_wave_pin_a(ch1_wave_pin_a),
		.ch1_wave_pin_a_oe(), .ch2_wave_pin_a(ch2_wave_pin_a),
		.ch2_wave_pin_a_oe(ch2_wave_pin_a_oe),
		.ch1_a_match_irq(irq[0]), .ch1_b_match_irq(irq[1]),
		.ch1_wrap_irq(irq[2]), .ch2_a_match_irq(irq[3]),
		.ch2_b_match_irq(irq[4]), .ch2_wrap_irq(irq[5]), .irq_top(irq_top));

	ext_clock_source i_src (.clk_sys(clk_sys), .en(src_en), .ext_clk(ext_clk));

	// ==========================================================
	// helpers
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	function automatic logic [15:0] pick(input int s);
		case (s)
			0: return ch1_count_value;
			1: return ch2_count_value;
			2: return {10'h000, timer_status_reg};
			3: return {10'h000, irq};
			4: return {13'h0000, irq_top};
			5: return {15'h0000, ch1_wave_pin_a};
			6: return ch2_reg_b;
			7: return {15'h0000, timer_status_reg[4]};
			default: return {14'h0000, ch2_wave_pin_a_oe, ch2_wave_pin_a};
		endcase
	endfunction
	task automatic check(input int s, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm[s], exp, seen);
		end
	endtask
	task automatic note(input int s, input logic [15:0] exp);
		sq.push_back(s);
		eq.push_back(exp);
	endtask
	task step();
		@(negedge clk_sys);
	endtask
	task conclude();
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			conclude();
		end
	end
	// monitor: every queued note, oldest first, against settled outputs
	initial begin
		int s;
		forever begin
			@(negedge clk_sys);
			#1;
			while (sq.size() > 0) begin
				s = sq.pop_front();
				check(s, pick(s), eq.pop_front());
			end
		end
	end

	// ==========================================================
	// stimulus
	initial begin
		reset_n = 1'b0;
		module_stop = 1'b0;
		count_start = 2'b00;
		clk_sel[0] = timer_pkg::CLK_INTERNAL;
		clk_sel[1] = timer_pkg::CLK_INTERNAL;
		clear_sel[0] = timer_pkg::CLR_REG_A;
		clear_sel[1] = timer_pkg::CLR_OFF;
		io_level_control[0] = timer_pkg::ACT_TOGGLE;
		io_level_control[1] = timer_pkg::ACT_NONE;
		pwm2_mode = 2'b00;
		io_initial_level = 2'b00;
		{count_wr, reg_a_wr, reg_b_wr} = 6'h00;
		{capture_b_mode, capture_b_req, io_initial_load} = 6'h00;
		cpu_wdata = 16'h0002;
		match_a_irq_enable = 2'b01;
		match_b_irq_enable = 2'b10;
		overflow_irq_enable = 2'b10;
		{status_rd, status_wr} = 2'b00;
		status_wdata = 6'h00;
		src_en = 1'b0;
		repeat (4) step();
		reset_n = 1'b1;
		note(4, 16'h0007);
		reg_a_wr[0] = 1'b1;
		step();
		reg_a_wr[0] = 1'b0;
		count_start[0] = 1'b1;
		step();
		note(0, 16'h0001);
		step();
		note(0, 16'h0002);
		reg_a_wr[0] = 1'b1;
		step();
		note(0, 16'h0003);
		note(2, 16'h0000);
		reg_a_wr[0] = 1'b0;
		count_wr[0] = 1'b1;
		cpu_wdata = 16'h0001;
		step();
		note(0, 16'h0001);
		count_wr[0] = 1'b0;
		repeat (2) step();
		note(0, 16'h0000);
		note(2, 16'h0001);
		note(3, 16'h0001);
		step();
		note(5, 16'h0001);
		step();
		count_wr[0] = 1'b1;
		cpu_wdata = 16'h0005;
		step();
		note(0, 16'h0000);
		count_wr[0] = 1'b0;
		step();
		note(5, 16'h0000);
		count_start[0] = 1'b0;
		// external clock modes on ch2
		for (int m = 1; m < 4; m++) begin
			clk_sel[1] = timer_pkg::clk_sel_e'(m);
			count_wr[1] = 1'b1;
			cpu_wdata = 16'h0000;
			count_start[1] = 1'b1;
			step();
			count_wr[1] = 1'b0;
			src_en = 1'b1;
			repeat (12) step();
			src_en = 1'b0;
			repeat (4) step();
			note(1, m == 3 ? 16'h0004 : 16'h0002);
		end
		clk_sel[1] = timer_pkg::CLK_INTERNAL;
		r = rnd() & 16'h7FFF;
		count_wr[1] = 1'b1;
		cpu_wdata = r;
		step();
		note(1, r);
		module_stop = 1'b1;
		cpu_wdata = 16'h1234;
		repeat (2) step();
		note(1, r);
		module_stop = 1'b0;
		count_wr[1] = 1'b0;
		step();
		note(1, r + 16'h0001);
		count_wr[1] = 1'b1;
		cpu_wdata = 16'hFFFF;
		step();
		count_wr[1] = 1'b0;
		step();
		note(1, 16'h0000);
		note(2, 16'h0039);
		note(4, 16'h0000);
		count_start[1] = 1'b0;
		status_wr = 1'b1;
		step();
		note(2, 16'h0039);
		status_wr = 1'b0;
		status_rd = 1'b1;
		step();
		status_rd = 1'b0;
		status_wr = 1'b1;
		status_wdata = 6'h3E;
		step();
		status_wr = 1'b0;
		note(2, 16'h0038);
		note(3, 16'h0030);
		note(4, 16'h0004);
		step();
		match_b_irq_enable[1] = 1'b0;
		note(4, 16'h0005);
		// pwm mode 2: reg b is the cycle, reg a the duty
		pwm2_mode[0] = 1'b1;
		clear_sel[0] = timer_pkg::CLR_REG_B;
		io_level_control[0] = timer_pkg::ACT_LOW;
		io_initial_level[0] = 1'b1;
		reg_b_wr[0] = 1'b1;
		cpu_wdata = 16'h0003;
		step();
		reg_b_wr[0] = 1'b0;
		reg_a_wr[0] = 1'b1;
		cpu_wdata = 16'h0001;
		step();
		reg_a_wr[0] = 1'b0;
		count_wr[0] = 1'b1;
		cpu_wdata = 16'h0000;
		step();
		count_wr[0] = 1'b0;
		count_start[0] = 1'b1;
		for (int i = 1; i < 13; i++) begin
			step();
			note(0, 16'(i % 4));
			if (i % 4 == 3)
				note(5, 16'h0000);
			if (i > 4 && i % 4 == 1)
				note(5, 16'h0001);
		end
		// ch2 register b as capture, flag cleared first
		capture_b_mode[1] = 1'b1;
		status_rd = 1'b1;
		step();
		status_rd = 1'b0;
		status_wr = 1'b1;
		status_wdata = 6'h2F;
		count_start[1] = 1'b1;
		step();
		status_wr = 1'b0;
		note(7, 16'h0000);
		capture_b_req[1] = 1'b1;
		step();
		capture_b_req[1] = 1'b0;
		note(6, 16'h0001);
		note(7, 16'h0001);
		io_initial_level[1] = 1'b1;
		io_initial_load[1] = 1'b1;
		step();
		io_initial_load[1] = 1'b0;
		note(8, 16'h0003);
		step();
		conclude();
	end
endmodule
